// file: design/spstk_entry.sv
// One stack entry byte with a registered value.
// Assumes the parent resolves shift versus software-write priority.
module spstk_entry #(
	parameter int unsigned WIDTH = 8,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	input wire logic ref_clk_in,
	input wire logic rst_b_in,
	input wire logic load_in,
	input wire logic [WIDTH-1:0] data_in,
	output logic [WIDTH-1:0] value_out
);
	logic [WIDTH-1:0] value_q;
	logic [WIDTH-1:0] value_d;

	always_comb begin
		value_d = value_q;
		if (load_in) begin
			value_d = data_in;
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			value_q <= RESET_VAL;
		end else begin
			value_q <= value_d;
		end
	end

	assign value_out = value_q;
endmodule // spstk_entry

// file: design/spstk_pkg.sv
// Package for the page context stack: addresses, widths, reset values.
// Assumes a byte-wide special-function register port from the core.
package spstk_pkg;
	localparam int unsigned SPSTK_DATA_W = 8;
	localparam int unsigned SPSTK_ADDR_W = 8;
	localparam int unsigned SPSTK_DEPTH = 3;
	localparam logic [7:0] SPSTK_ADDR_ACTIVE = 8'h84;
	localparam logic [7:0] SPSTK_ADDR_SECOND = 8'h85;
	localparam logic [7:0] SPSTK_ADDR_BOTTOM = 8'h86;
	localparam logic [7:0] SPSTK_ENTRY_RESET = 8'h00;
	localparam logic SPSTK_AUTO_EN_RESET = 1'b1;
	localparam int unsigned SPSTK_IDX_ACTIVE = 0;
	localparam int unsigned SPSTK_IDX_SECOND = 1;
	localparam int unsigned SPSTK_IDX_BOTTOM = 2;
endpackage : spstk_pkg

// file: design/spstk_top.sv
// Three-entry page context stack reached over the core's byte register port.
// Assumes one-cycle push/pop strobes from the core's interrupt logic and
// write/read strobes that are never asserted on the same cycle.
// Assumes the paging enable comes from a control register outside this
// block, which owns its default-on reset value.
// Assumes every input is synchronous to the core clock.

// Notes on behaviour
// - Three byte entries: active, second, bottom
// - Register access never shifts the stack
// - Shift only on interrupt entry or return
// - Second-entry write becomes active on return
// - Second-entry read returns middle entry
// - Bottom-entry write becomes second on return
// - Bottom-entry read returns third, no side effects
// - Second entry at 0x85, RW, resets zero
// - Bottom entry at 0x86, RW, resets zero
// - Entry: middle to bottom, active to middle
// - Return: middle to active, bottom to middle
// - Auto paging enable, defaults on, gates shifts
// - Active selector at 0x84, write no push
module spstk_top #(
	parameter int unsigned DATA_W = spstk_pkg::SPSTK_DATA_W,
	parameter int unsigned DEPTH = spstk_pkg::SPSTK_DEPTH
) (
	input wire logic ref_clk_in,
	input wire logic rst_b_in,
	input wire logic auto_paging_enable_in,
	input wire logic irq_push_in,
	input wire logic [DATA_W-1:0] irq_page_in,
	input wire logic return_from_interrupt_in,
	input wire logic [spstk_pkg::SPSTK_ADDR_W-1:0] sfr_addr_in,
	input wire logic sfr_wr_in,
	input wire logic [DATA_W-1:0] sfr_wdata_in,
	input wire logic sfr_rd_in,
	output logic [DATA_W-1:0] sfr_rdata_out,
	output logic sfr_rvalid_out,
	output logic [DATA_W-1:0] active_page_selector_out,
	output logic [DATA_W-1:0] page_stack_second_entry_out,
	output logic [DATA_W-1:0] page_stack_bottom_entry_out
);
	// Elaboration checks: the shift wiring below is written for three bytes
	if (DATA_W != spstk_pkg::SPSTK_DATA_W) begin : g_width_check
		$error("spstk_top: only byte-wide entries are supported");
	end
	if (DEPTH != spstk_pkg::SPSTK_DEPTH) begin : g_depth_check
		$error("spstk_top: only a stack depth of three is supported");
	end
	if (spstk_pkg::SPSTK_IDX_BOTTOM != DEPTH - 1) begin : g_index_check
		$error("spstk_top: bottom index must be the last entry");
	end
	if (spstk_pkg::SPSTK_IDX_SECOND != spstk_pkg::SPSTK_IDX_ACTIVE + 1 ||
		spstk_pkg::SPSTK_IDX_BOTTOM != spstk_pkg::SPSTK_IDX_SECOND + 1) begin : g_order_check
		$error("spstk_top: entries must run from active to bottom");
	end
	if (spstk_pkg::SPSTK_ADDR_SECOND == spstk_pkg::SPSTK_ADDR_ACTIVE ||
		spstk_pkg::SPSTK_ADDR_BOTTOM == spstk_pkg::SPSTK_ADDR_SECOND ||
		spstk_pkg::SPSTK_ADDR_BOTTOM == spstk_pkg::SPSTK_ADDR_ACTIVE) begin : g_addr_check
		$error("spstk_top: entry addresses must be distinct");
	end


	// One-hot stack operation: hold, push on interrupt entry, pop on
	// return; at most one is chosen in any cycle
	typedef enum logic [2:0] {
		SPSTK_OP_HOLD = 3'b001,
		SPSTK_OP_PUSH = 3'b010,
		SPSTK_OP_POP = 3'b100
	} spstk_op_type;

	spstk_op_type op;
	logic [DATA_W-1:0] entry_val [DEPTH];
	logic [DATA_W-1:0] entry_din [DEPTH];
	logic entry_ld [DEPTH];
	logic [DATA_W-1:0] rdata_d;
	logic [DATA_W-1:0] rdata_q;
	logic rvalid_d;
	logic rvalid_q;
	logic [spstk_pkg::SPSTK_ADDR_W-1:0] entry_addr [DEPTH];
	logic push_req;
	logic pop_req;

	// Each entry answers at one fixed address on every page
	assign entry_addr[spstk_pkg::SPSTK_IDX_ACTIVE] =
		spstk_pkg::SPSTK_ADDR_ACTIVE;
	assign entry_addr[spstk_pkg::SPSTK_IDX_SECOND] =
		spstk_pkg::SPSTK_ADDR_SECOND;
	assign entry_addr[spstk_pkg::SPSTK_IDX_BOTTOM] =
		spstk_pkg::SPSTK_ADDR_BOTTOM;

	// Disabled paging freezes the stack: the core then keeps its own page
	// and a return leaves the entries exactly as software last wrote them
	assign push_req = auto_paging_enable_in && irq_push_in;
	assign pop_req = auto_paging_enable_in &&
		return_from_interrupt_in;

	// Pushes win over a stray pop in the same cycle, so an interrupt that
	// lands on a return never loses the page of the interrupting source
	always_comb begin
		op = SPSTK_OP_HOLD;
		if (push_req) begin
			op = SPSTK_OP_PUSH;
		end else if (pop_req) begin
			op = SPSTK_OP_POP;
		end
	end

	// Address decode ignores the active page: all entries sit on every page.
	// A push moves every byte one place down and loses the old bottom; a
	// pop moves every byte one place up and leaves the bottom as it was, so
	// two pops in a row leave copies of the bottom in the upper entries.
	for (genvar i = 0; i < DEPTH; i++) begin : g_entry
		logic sw_hit;
		logic pop_ld;
		logic [DATA_W-1:0] push_src;
		logic [DATA_W-1:0] pop_src;

		assign sw_hit = sfr_wr_in && (sfr_addr_in == entry_addr[i]);

		// Which byte an entry takes on a push is fixed at elaboration
		if (i == spstk_pkg::SPSTK_IDX_ACTIVE) begin : g_push_top
			assign push_src = irq_page_in;
		end else begin : g_push_below
			assign push_src = entry_val[i-1];
		end

		// Nothing sits beneath the bottom, so on a pop only a software
		// write can change it; the upper entries take the byte below
		if (i == DEPTH - 1) begin : g_pop_last
			assign pop_ld = sw_hit;
			assign pop_src = sfr_wdata_in;
		end else begin : g_pop_upper
			assign pop_ld = 1'b1;
			assign pop_src = entry_val[i+1];
		end

		always_comb begin
			entry_ld[i] = 1'b0;
			entry_din[i] = sfr_wdata_in;
			case (op)
				SPSTK_OP_PUSH: begin
					// Shift takes priority over a coinciding write
					entry_ld[i] = 1'b1;
					entry_din[i] = push_src;
				end
				SPSTK_OP_POP: begin
					entry_ld[i] = pop_ld;
					entry_din[i] = pop_src;
				end
				SPSTK_OP_HOLD: begin
					entry_ld[i] = sw_hit;
					entry_din[i] = sfr_wdata_in;
				end
				default: begin
					entry_ld[i] = 1'b0;
					entry_din[i] = sfr_wdata_in;
				end
			endcase
		end

		// Each byte is its own register, so the outputs leave from flops

		spstk_entry #(
			.WIDTH(DATA_W),
			.RESET_VAL(spstk_pkg::SPSTK_ENTRY_RESET)
		) u_entry (
			.ref_clk_in(ref_clk_in),
			.rst_b_in(rst_b_in),
			.load_in(entry_ld[i]),
			.data_in(entry_din[i]),
			.value_out(entry_val[i])
		);
	end

	// Reads return one cycle later and change nothing. The strobe marks
	// the data; between reads the last byte read stays on the data port,
	// and an unmapped read returns zero with no strobe. A read in the
	// same cycle as a write or shift sees the value before that change.
	always_comb begin
		rdata_d = rdata_q;
		rvalid_d = 1'b0;
		if (sfr_rd_in) begin
			rvalid_d = 1'b1;
			case (sfr_addr_in)
				spstk_pkg::SPSTK_ADDR_ACTIVE: begin
					rdata_d = entry_val[spstk_pkg::SPSTK_IDX_ACTIVE];
				end
				spstk_pkg::SPSTK_ADDR_SECOND: begin
					rdata_d = entry_val[spstk_pkg::SPSTK_IDX_SECOND];
				end
				spstk_pkg::SPSTK_ADDR_BOTTOM: begin
					rdata_d = entry_val[spstk_pkg::SPSTK_IDX_BOTTOM];
				end
				default: begin
					rvalid_d = 1'b0;
					rdata_d = spstk_pkg::SPSTK_ENTRY_RESET;
				end
			endcase
		end
	end

	// Read port register; reset leaves both strobe and data low
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rdata_q <= spstk_pkg::SPSTK_ENTRY_RESET;
			rvalid_q <= 1'b0;
		end else begin
			rdata_q <= rdata_d;
			rvalid_q <= rvalid_d;
		end
	end

	assign sfr_rdata_out = rdata_q;
	assign sfr_rvalid_out = rvalid_q;
	// Entry values are flip-flop outputs inside the entry modules; the
	// core's page decode reads the active selector from here directly
	assign active_page_selector_out = entry_val[spstk_pkg::SPSTK_IDX_ACTIVE];
	assign page_stack_second_entry_out =
		entry_val[spstk_pkg::SPSTK_IDX_SECOND];
	assign page_stack_bottom_entry_out =
		entry_val[spstk_pkg::SPSTK_IDX_BOTTOM];
endmodule // spstk_top

// file: verif/spstk_chk_assertions.sv
// Checker on the page stack ports.
// Assumes one core clock and an active-low reset.
module spstk_chk (
	input wire logic ref_clk_in,
	input wire logic rst_b_in,
	input wire logic auto_paging_enable_in,
	input wire logic irq_push_in,
	input wire logic [7:0] irq_page_in,
	input wire logic return_from_interrupt_in,
	input wire logic [7:0] sfr_addr_in,
	input wire logic sfr_wr_in,
	input wire logic [7:0] sfr_wdata_in,
	input wire logic sfr_rd_in,
	input wire logic [7:0] sfr_rdata_out,
	input wire logic sfr_rvalid_out,
	input wire logic [7:0] active_page_selector_out,
	input wire logic [7:0] page_stack_second_entry_out,
	input wire logic [7:0] page_stack_bottom_entry_out
);
	wire [7:0] a = active_page_selector_out;
	wire [7:0] s = page_stack_second_entry_out;
	wire [7:0] b = page_stack_bottom_entry_out;
	wire [7:0] ad = sfr_addr_in;
	wire psh = auto_paging_enable_in && irq_push_in;
	wire pop = auto_paging_enable_in && return_from_interrupt_in && !psh;
	wire wr = sfr_wr_in && !psh;
	default clocking @(posedge ref_clk_in);
	endclocking
	default disable iff (!rst_b_in);
	sequence push_s;
		psh;
	endsequence
	sequence pop_s;
		pop && !sfr_wr_in;
	endsequence
	push_moves_a: assert property (push_s |=> a == $past(irq_page_in) &&
		s == $past(a) && b == $past(s)) else $error("push");
	pop_moves_a: assert property (pop_s |=> a == $past(s) &&
		s == $past(b) && b == $past(b)) else $error("pop");
	stack_hold_a: assert property (!psh && !pop && !sfr_wr_in |=>
		$stable({a, s, b})) else $error("moved");
	wr_active_a: assert property (wr && !pop && ad == 8'h84 |=>
		a == $past(sfr_wdata_in) && $stable({s, b})) else $error("wr84");
	wr_second_a: assert property (wr && !pop && ad == 8'h85 |=>
		s == $past(sfr_wdata_in) && $stable({a, b})) else $error("wr85");
	wr_bottom_a: assert property (wr && ad == 8'h86 |=>
		b == $past(sfr_wdata_in)) else $error("wr86");
	rd_second_a: assert property (sfr_rd_in && ad == 8'h85 |=>
		sfr_rvalid_out && sfr_rdata_out == $past(s)) else $error("rd85");
	rd_bottom_a: assert property (sfr_rd_in && ad == 8'h86 |=>
		sfr_rvalid_out && sfr_rdata_out == $past(b)) else $error("rd86");
endmodule // spstk_chk
bind spstk_top spstk_chk chk (.*);

// file: verif/spstk_core_model.sv
// Core interrupt entry and return strobes for the page stack.
// Assumes the bench calls enter and leave; strobes move at falling edges.
module spstk_core_model (
	input wire logic ref_clk_in,
	output logic irq_push_out,
	output logic rfi_out,
	output logic [7:0] irq_page_out
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		irq_push_out = 0;
		rfi_out = 0;
		irq_page_out = 8'h00;
	end
	// Page shows its inverse once it is no longer sampled
	task automatic enter(input logic [7:0] p);
		@(negedge ref_clk_in);
		irq_push_out = 1;
		irq_page_out = p;
		@(negedge ref_clk_in);
		irq_push_out = 0;
		irq_page_out = ~p;
	endtask
	task automatic leave();
		@(negedge ref_clk_in);
		rfi_out = 1;
		@(negedge ref_clk_in);
		rfi_out = 0;
	endtask
endmodule // spstk_core_model

// file: verif/test_spstk_top.sv
// Bench for the page stack: register port, pushes, pops, priority.
// Assumes the core model drives the interrupt strobes.
module test_spstk_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, rst_b = 0, en = 1, wr = 0, rd = 0;
	logic [7:0] ad = 8'h00, wd = 8'h00;
	wire logic push, rfi, rv;
	wire logic [7:0] pg, rdat, a, s, b;
	int errors = 0, cmp_count = 0;
	spstk_top dut (.ref_clk_in(clk), .rst_b_in(rst_b),
		.auto_paging_enable_in(en), .irq_push_in(push), .irq_page_in(pg),
		.return_from_interrupt_in(rfi), .sfr_addr_in(ad), .sfr_wr_in(wr),
		.sfr_wdata_in(wd), .sfr_rd_in(rd), .sfr_rdata_out(rdat),
		.sfr_rvalid_out(rv), .active_page_selector_out(a),
		.page_stack_second_entry_out(s), .page_stack_bottom_entry_out(b));
	spstk_core_model core (.ref_clk_in(clk), .irq_push_out(push),
		.rfi_out(rfi), .irq_page_out(pg));
	initial forever #2 clk = ~clk;
	task automatic cmp(input logic [23:0] got, exp);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wrt(input logic [7:0] x, d);
		@(negedge clk);
		{wr, ad, wd} = {1'b1, x, d};
		@(negedge clk);
		wr = 0;
	endtask
	task automatic rdc(input logic [7:0] x, input logic [8:0] e);
		@(negedge clk);
		{rd, ad} = {1'b1, x};
		@(negedge clk);
		rd = 0;
		cmp(24'({rv, rdat}), 24'(e));
	endtask
	task automatic t_regs;
		rdc(8'h85, 9'h100);
		cmp({a, s, b}, 24'h00_0000);
		wrt(8'h84, 8'h11);
		wrt(8'h85, 8'h22);
		wrt(8'h86, 8'h33);
		cmp({a, s, b}, 24'h11_2233);
		rdc(8'h85, 9'h122);
		rdc(8'h86, 9'h133);
		rdc(8'h87, 9'h000);
		$display("regs done");
	endtask
	task automatic t_nest;
		core.enter(8'h02);
		core.enter(8'h00);
		cmp({a, s, b}, 24'h00_0211);
		core.leave();
		cmp({a, s, b}, 24'h02_1111);
		core.leave();
		core.enter(8'h44);
		wrt(8'h86, 8'h77);
		wrt(8'h85, 8'h5a);
		core.leave();
		cmp({a, s, b}, 24'h5a_7777);
		$display("nest done");
	endtask
	task automatic t_prio;
		en = 0;
		core.enter(8'h99);
		core.leave();
		cmp({a, s, b}, 24'h5a_7777);
		en = 1;
		fork core.enter(8'h66); wrt(8'h84, 8'hff); join
		cmp({a, s, b}, 24'h66_5a77);
		fork core.leave(); wrt(8'h86, 8'h0c); join
		cmp({a, s, b}, 24'h5a_770c);
		$display("prio done");
	endtask
	task automatic t_rst;
		@(negedge clk);
		rst_b = 0;
		@(negedge clk);
		cmp({a, s, b}, 24'h00_0000);
		cmp(24'({rv, rdat}), 24'h00_0000);
		rst_b = 1;
		rdc(8'h84, 9'h100);
		$display("reset done");
	endtask
	task automatic end_sim;
		$display("errors %0d compares %0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		repeat (12) @(negedge clk);
		rst_b = 1;
		t_regs();
		t_nest();
		t_prio();
		t_rst();
		end_sim();
	end
	// Tests need under 200 cycles; this allows ample margin
	initial begin
		#20000;
		errors++;
		end_sim();
	end
endmodule // test_spstk_top
